// File: core/sfr_pkg.sv
// Constants and types of the serial flash read path
package sfr_pkg;

	// Array geometry
	localparam int unsigned SFR_PAGES      = 8192;
	localparam int unsigned SFR_PAGE_BYTES = 528;
	localparam int unsigned SFR_PAGE_W     = 13;
	localparam int unsigned SFR_OFF_W      = 10;
	localparam logic [9:0]  SFR_LAST_OFF   = 10'h20F;
	localparam logic [7:0]  SFR_OOR_BYTE   = 8'hFF;

	// Opcodes
	localparam logic [7:0] SFR_OPC_CONT_RD = 8'hE8;
	localparam logic [7:0] SFR_OPC_PAGE_RD = 8'hD2;
	localparam logic [7:0] SFR_OPC_BUF1_RD = 8'hD4;
	localparam logic [7:0] SFR_OPC_BUF2_RD = 8'hD6;

	// Phase lengths, as last bit index
	localparam logic [5:0] SFR_OPC_LAST   = 6'h07;
	localparam logic [5:0] SFR_ADDR_LAST  = 6'h17;
	localparam logic [5:0] SFR_DMY_M_LAST = 6'h1F;
	localparam logic [5:0] SFR_DMY_B_LAST = 6'h07;

	// Address field positions in the 24-bit sequence
	localparam int unsigned SFR_PAGE_MSB = 22;
	localparam int unsigned SFR_PAGE_LSB = 10;
	localparam int unsigned SFR_OFF_MSB  = 9;

	// Read kinds
	typedef enum logic [1:0] {
		SFR_RD_CONT = 2'h0,
		SFR_RD_PAGE = 2'h1,
		SFR_RD_BUF1 = 2'h2,
		SFR_RD_BUF2 = 2'h3
	} sfr_mode_t;

	// Command sequencer states
	typedef enum logic [5:0] {
		SFR_ST_IDLE   = 6'h01,
		SFR_ST_OPC    = 6'h02,
		SFR_ST_ADDR   = 6'h04,
		SFR_ST_DUMMY  = 6'h08,
		SFR_ST_DATA   = 6'h10,
		SFR_ST_IGNORE = 6'h20
	} sfr_state_t;

endpackage : sfr_pkg

// File: core/sfr_pin_sync.sv
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/10ps
`default_nettype none
module sfr_pin_sync #(
	parameter int unsigned    W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	// Both stages; first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : sfr_pin_sync
`default_nettype wire

// File: core/sfr_store.sv
// Main array and two SRAM buffers with one registered read port
`timescale 1ns/10ps
`default_nettype none
module sfr_store
	import sfr_pkg::*;
#(
	parameter int unsigned PAGES = SFR_PAGES
) (
	input  wire logic                  core_clk,
	input  wire sfr_mode_t             rd_mode,
	input  wire logic                  rd_en,
	input  wire logic [SFR_PAGE_W-1:0] rd_page,
	input  wire logic [SFR_OFF_W-1:0]  rd_off,
	output var  logic [7:0]            rd_data,
	input  wire logic                  ld_en,
	input  wire sfr_mode_t             ld_mode,
	input  wire logic [SFR_PAGE_W-1:0] ld_page,
	input  wire logic [SFR_OFF_W-1:0]  ld_off,
	input  wire logic [7:0]            ld_data
);

	localparam int unsigned DEPTH = PAGES * SFR_PAGE_BYTES;
	localparam int unsigned AW    = $clog2(DEPTH);
	localparam logic [AW-1:0] PB  = AW'(SFR_PAGE_BYTES);

	logic [7:0] arr  [DEPTH];
	logic [7:0] buf1 [SFR_PAGE_BYTES];
	logic [7:0] buf2 [SFR_PAGE_BYTES];

	// Flat array index from page and byte
	function automatic logic [AW-1:0] loc_idx(
		input logic [SFR_PAGE_W-1:0] page,
		input logic [SFR_OFF_W-1:0]  off
	);
		logic [AW-1:0] p;
		p = AW'(page);
		return p * PB + AW'(off);
	endfunction : loc_idx

	wire logic [AW-1:0] rd_idx  = loc_idx(rd_page, rd_off);
	wire logic [AW-1:0] ld_idx  = loc_idx(ld_page, ld_off);
	wire logic          rd_in   = rd_off <= SFR_LAST_OFF;
	wire logic          ld_in   = ld_off <= SFR_LAST_OFF;
	wire logic          rd_arr  = rd_mode inside {SFR_RD_CONT, SFR_RD_PAGE};

	// Preload port for bench and boot; the read path never writes
	always_ff @(posedge core_clk) begin
		if (ld_en && ld_in) begin
			unique case (ld_mode)
				SFR_RD_BUF1: buf1[ld_off] <= ld_data;
				SFR_RD_BUF2: buf2[ld_off] <= ld_data;
				default:     arr[ld_idx]  <= ld_data;
			endcase
		end
	end

	// Array reads bypass the buffers
	always_ff @(posedge core_clk) begin
		if (rd_en) begin
			if (!rd_in)
				rd_data <= SFR_OOR_BYTE;
			else if (rd_arr)
				rd_data <= arr[rd_idx];
			else if (rd_mode == SFR_RD_BUF1)
				rd_data <= buf1[rd_off];
			else
				rd_data <= buf2[rd_off];
		end
	end

endmodule : sfr_store
`default_nettype wire

// File: core/sfr_read_path.sv
// Serial command front end and read paths of the page flash
`timescale 1ns/10ps
`default_nettype none
module sfr_read_path
	import sfr_pkg::*;
#(
	parameter int unsigned PAGES = SFR_PAGES
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  cs_n,
	input  wire logic                  sck,
	input  wire logic                  si,
	output var  logic                  so_o,
	output var  logic                  so_oe,
	input  wire logic                  ld_en,
	input  wire sfr_mode_t             ld_mode,
	input  wire logic [SFR_PAGE_W-1:0] ld_page,
	input  wire logic [SFR_OFF_W-1:0]  ld_off,
	input  wire logic [7:0]            ld_data
);

	localparam logic [SFR_PAGE_W-1:0] LAST_PAGE = SFR_PAGE_W'(PAGES - 1);

	////////////////////////////////////////////////////////////////////////
	// Pin sampling

	logic       cs_n_s;
	logic       sck_s;
	logic       si_s;
	logic       sck_d_r;

	sfr_pin_sync #(
		.W       (3),
		.RST_VAL (3'h4)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.d        ({cs_n, sck, si}),
		.q        ({cs_n_s, sck_s, si_s})
	);

	// Delayed clock for edge finding
	always_ff @(posedge core_clk) begin
		if (rst)
			sck_d_r <= 1'b0;
		else
			sck_d_r <= sck_s;
	end

	// Edges of the serial clock; either idle level works
	wire logic sck_rise = sck_s & ~sck_d_r;
	wire logic sck_fall = ~sck_s & sck_d_r;

	////////////////////////////////////////////////////////////////////////
	// State and data registers

	sfr_state_t             state_r;
	sfr_state_t             state_nxt;
	sfr_mode_t              mode_r;
	logic [5:0]             cnt_r;
	logic [7:0]             opc_sh_r;
	logic [23:0]            adr_sh_r;
	logic [SFR_PAGE_W-1:0]  page_r;
	logic [SFR_OFF_W-1:0]   off_r;
	logic [7:0]             nxt_byte_r;
	logic [7:0]             sh_r;
	logic [2:0]             bit_r;
	logic                   rd_vld_r;
	logic [7:0]             rd_data;

	////////////////////////////////////////////////////////////////////////
	// Decoding

	// Opcode to read kind, with a valid flag
	function automatic logic [2:0] opc_decode(input logic [7:0] opc);
		unique case (opc)
			SFR_OPC_CONT_RD: return {1'b1, SFR_RD_CONT};
			SFR_OPC_PAGE_RD: return {1'b1, SFR_RD_PAGE};
			SFR_OPC_BUF1_RD: return {1'b1, SFR_RD_BUF1};
			SFR_OPC_BUF2_RD: return {1'b1, SFR_RD_BUF2};
			default:         return {1'b0, SFR_RD_CONT};
		endcase
	endfunction : opc_decode

	// Full words including the bit on the line now
	wire logic [7:0]  opc_full = {opc_sh_r[6:0], si_s};
	wire logic [23:0] adr_full = {adr_sh_r[22:0], si_s};
	wire logic [2:0]  opc_dec  = opc_decode(opc_full);
	wire logic        opc_ok   = opc_dec[2];
	wire sfr_mode_t   opc_mode = sfr_mode_t'(opc_dec[1:0]);
	wire logic        is_buf   = mode_r inside {SFR_RD_BUF1, SFR_RD_BUF2};

	// Last bit index of the current phase
	wire logic [5:0] dmy_last   = is_buf ? SFR_DMY_B_LAST
	                                     : SFR_DMY_M_LAST;
	wire logic [5:0] phase_last = (state_r == SFR_ST_OPC)  ? SFR_OPC_LAST :
	                              (state_r == SFR_ST_ADDR) ? SFR_ADDR_LAST :
	                              dmy_last;
	wire logic       phase_end  = sck_rise && (cnt_r == phase_last);

	// Select framing; a high select aborts everything
	wire logic cs_act   = ~cs_n_s;
	wire logic dmy_end  = (state_r == SFR_ST_DUMMY) && phase_end;
	wire logic data_sh  = (state_r == SFR_ST_DATA) && sck_fall;
	wire logic byte_new = data_sh && (bit_r == 3'h0);

	// Fetch at end of dummy, then one byte ahead at each byte start
	wire logic rd_go = cs_act && (dmy_end || byte_new);

	// Next location after the current one
	wire logic                  off_last = off_r >= SFR_LAST_OFF;
	wire logic                  pg_last  = page_r == LAST_PAGE;
	wire logic [SFR_OFF_W-1:0]  off_nxt  = off_last ? '0 : off_r + 1'b1;
	wire logic                  pg_step  = (mode_r == SFR_RD_CONT) && off_last;
	wire logic [SFR_PAGE_W-1:0] pg_inc   = pg_last ? '0
	                                              : page_r + 1'b1;
	wire logic [SFR_PAGE_W-1:0] page_nxt = pg_step ? pg_inc
	                                               : page_r;

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		if (!cs_act)
			state_nxt = SFR_ST_IDLE;
		else begin
			unique case (state_r)
				SFR_ST_IDLE:   state_nxt = SFR_ST_OPC;
				SFR_ST_OPC:    if (phase_end)
					state_nxt = opc_ok ? SFR_ST_ADDR : SFR_ST_IGNORE;
				SFR_ST_ADDR:   if (phase_end)
					state_nxt = SFR_ST_DUMMY;
				SFR_ST_DUMMY:  if (phase_end)
					state_nxt = SFR_ST_DATA;
				SFR_ST_DATA:   state_nxt = SFR_ST_DATA;
				SFR_ST_IGNORE: state_nxt = SFR_ST_IGNORE;
				default:       state_nxt = SFR_ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer and bit counter

	always_ff @(posedge core_clk) begin
		if (rst)
			state_r <= SFR_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Bits within the phase; cleared at each phase change
	always_ff @(posedge core_clk) begin
		if (rst || state_nxt != state_r)
			cnt_r <= '0;
		else if (sck_rise)
			cnt_r <= cnt_r + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Opcode and address capture

	// Shift in on rising edges, most significant first
	always_ff @(posedge core_clk) begin
		if (rst) begin
			opc_sh_r <= '0;
			adr_sh_r <= '0;
		end else if (sck_rise && cs_act) begin
			if (state_r == SFR_ST_OPC)
				opc_sh_r <= opc_full;
			if (state_r == SFR_ST_ADDR)
				adr_sh_r <= adr_full;
		end
	end

	// Read kind latched at the end of the opcode
	always_ff @(posedge core_clk) begin
		if (rst)
			mode_r <= SFR_RD_CONT;
		else if ((state_r == SFR_ST_OPC) && phase_end && opc_ok)
			mode_r <= opc_mode;
	end

	// Start location, then the running address counter
	always_ff @(posedge core_clk) begin
		if (rst) begin
			page_r <= '0;
			off_r  <= '0;
		end else if ((state_r == SFR_ST_ADDR) && phase_end) begin
			page_r <= is_buf ? '0
			                 : adr_full[SFR_PAGE_MSB:SFR_PAGE_LSB];
			off_r  <= adr_full[SFR_OFF_MSB:0];
		end else if (rd_go) begin
			page_r <= page_nxt;
			off_r  <= off_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Storage

	sfr_store #(
		.PAGES (PAGES)
	) u_store (
		.core_clk (core_clk),
		.rd_mode  (mode_r),
		.rd_en    (rd_go),
		.rd_page  (page_r),
		.rd_off   (off_r),
		.rd_data  (rd_data),
		.ld_en    (ld_en),
		.ld_mode  (ld_mode),
		.ld_page  (ld_page),
		.ld_off   (ld_off),
		.ld_data  (ld_data)
	);

	// Fetched byte lands in nxt_byte_r two cycles after the request
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_vld_r   <= 1'b0;
			nxt_byte_r <= '0;
		end else begin
			rd_vld_r <= rd_go;
			if (rd_vld_r)
				nxt_byte_r <= rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial output

	// New bit on each falling edge, most significant first
	always_ff @(posedge core_clk) begin
		if (rst || !cs_act || state_r != SFR_ST_DATA) begin
			sh_r  <= '0;
			bit_r <= '0;
			so_o  <= 1'b0;
		end else if (data_sh) begin
			bit_r <= bit_r + 1'b1;
			if (byte_new) begin
				so_o <= nxt_byte_r[7];
				sh_r <= {nxt_byte_r[6:0], 1'b0};
			end else begin
				so_o <= sh_r[7];
				sh_r <= {sh_r[6:0], 1'b0};
			end
		end
	end

	// Line driven only in the data phase
	assign so_oe = (state_r == SFR_ST_DATA);

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	wire logic nb_msb = nxt_byte_r[7];
	wire logic sh_msb = sh_r[7];

	a_oe_data_only: assert property (
		$rose(so_oe) |-> $past(dmy_end) && $past(cs_act))
		else $error("output enabled outside data phase");
	a_cs_rise_hiz: assert property (
		$rose(cs_n_s) |=> !so_oe && (state_r == SFR_ST_IDLE))
		else $error("output still driven after select rise");
	a_opc_shift: assert property (
		(state_r == SFR_ST_OPC) && sck_rise && cs_act
		|=> opc_sh_r[0] == $past(si_s))
		else $error("opcode bit not shifted in");
	a_opc_len: assert property (
		(state_r == SFR_ST_OPC) && cs_act && phase_end
		|=> state_r inside {SFR_ST_ADDR, SFR_ST_IGNORE} && cnt_r == 6'h00)
		else $error("opcode phase length wrong");
	a_addr_len: assert property (
		(state_r == SFR_ST_ADDR) && cs_act && sck_rise
		&& cnt_r == SFR_ADDR_LAST
		|=> state_r == SFR_ST_DUMMY)
		else $error("address phase length wrong");
	a_dummy_main: assert property (
		(state_r == SFR_ST_DUMMY) && !is_buf && sck_rise && cs_act
		&& cnt_r == SFR_DMY_M_LAST |=> state_r == SFR_ST_DATA)
		else $error("main dummy length wrong");
	a_dummy_buf: assert property (
		(state_r == SFR_ST_DUMMY) && is_buf && sck_rise && cs_act
		&& cnt_r == SFR_DMY_B_LAST |=> state_r == SFR_ST_DATA)
		else $error("buffer dummy length wrong");
	a_msb_first: assert property (
		byte_new && cs_act |=> so_o == $past(nb_msb))
		else $error("byte not started at its top bit");
	a_bit_shift: assert property (
		data_sh && !byte_new && cs_act |=> so_o == $past(sh_msb))
		else $error("data bit out of order");
	a_page_wrap: assert property (
		rd_go && mode_r == SFR_RD_PAGE && off_r == SFR_LAST_OFF
		|=> off_r == 10'h000 && $stable(page_r))
		else $error("page read left its page");
	a_next_page: assert property (
		rd_go && mode_r == SFR_RD_CONT && off_r == SFR_LAST_OFF && !pg_last
		|=> off_r == 10'h000 && page_r == $past(page_r) + 1'b1)
		else $error("continuous read missed next page");
	a_array_wrap: assert property (
		rd_go && mode_r == SFR_RD_CONT && off_r == SFR_LAST_OFF && pg_last
		|=> off_r == 10'h000 && page_r == 13'h0000)
		else $error("continuous read did not wrap");
	a_buf_wrap: assert property (
		rd_go && is_buf && off_r == SFR_LAST_OFF
		|=> off_r == 10'h000)
		else $error("buffer read did not wrap");
	a_fetch_ready: assert property (
		rd_go |-> ##2 rd_vld_r == 1'b0 && nxt_byte_r == $past(rd_data))
		else $error("prefetched byte not captured");

	c_cont_data: cover property (byte_new && mode_r == SFR_RD_CONT);
	c_page_wrap: cover property (rd_go && mode_r == SFR_RD_PAGE && off_last);
	c_buf2_data: cover property (byte_new && mode_r == SFR_RD_BUF2);
	c_bad_opc:   cover property (state_r == SFR_ST_IGNORE);

endmodule : sfr_read_path
`default_nettype wire

// File: verification/sfr_host_model.sv
// Behavioural serial host that frames read commands for the read path
`timescale 1ns/10ps
`default_nettype none
module sfr_host_model (
	input  wire logic core_clk,
	output var  logic cs_n,
	output var  logic sck,
	output var  logic si,
	input  wire logic so_o,
	input  wire logic so_oe
);
	logic       so_last = 1'b0;
	logic       so_w;
	logic       smp;
	logic       oe_bad;
	logic       oe_seen;
	logic [7:0] rx_q[$];

	////////////////////////////////////////////////////////////////////////
	// Released line toggles so a stale level never matches by chance
	assign so_w = so_oe ? so_o : ~so_last;

	// Last seen line level
	always_ff @(posedge core_clk) begin
		so_last <= so_w;
	end

	// Idle pins from time zero
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One serial clock: fall with new bit, rise, sample before next fall
	task automatic bit_cyc(input logic d);
		sck <= 1'b0;
		si  <= d;
		repeat (4) @(posedge core_clk);
		sck <= 1'b1;
		repeat (4) @(posedge core_clk);
		smp = so_w;
		if (so_oe === 1'b1) oe_seen = 1'b1;
	endtask : bit_cyc

	// Whole frame in clock mode 0 or 3, select held low throughout
	task automatic frame(input logic [7:0] opc, input logic [23:0] adr,
		input int ndmy, input int nbyte, input bit m3);
		logic [31:0] hdr;
		logic [7:0]  b;
		int          i;
		hdr     = {opc, adr};
		b       = 8'h00;
		oe_bad  = 1'b0;
		oe_seen = 1'b0;
		rx_q.delete();
		sck <= m3;
		repeat (4) @(posedge core_clk);
		cs_n <= 1'b0;
		for (i = 0; i < 32 + ndmy; i++) begin
			bit_cyc((i < 32) ? hdr[31 - i] : ~si);
			if (i < 31 + ndmy && so_oe !== 1'b0) oe_bad = 1'b1;
		end
		for (i = 0; i < nbyte * 8; i++) begin
			bit_cyc(~si);
			b = {b[6:0], smp};
			if (i % 8 == 7) rx_q.push_back(b);
		end
		if (!m3) begin
			sck <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
		cs_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		if (so_oe !== 1'b0) oe_bad = 1'b1;
	endtask : frame
endmodule : sfr_host_model
`default_nettype wire

// File: verification/serial_flash_read_path_tb_top.sv
// Self-checking testbench of the serial flash read path
`timescale 1ns/10ps
`default_nettype none
module serial_flash_read_path_tb_top;
	import sfr_pkg::*;
	localparam int unsigned PG = 4;
	logic                  core_clk = 1'b0;
	logic                  rst      = 1'b1;
	logic                  cs_n;
	logic                  sck;
	logic                  si;
	logic                  so_o;
	logic                  so_oe;
	logic                  ld_en    = 1'b0;
	sfr_mode_t             ld_mode  = SFR_RD_CONT;
	logic [SFR_PAGE_W-1:0] ld_page  = 13'h0000;
	logic [SFR_OFF_W-1:0]  ld_off   = 10'h000;
	logic [7:0]            ld_data  = 8'h00;
	int                    err_count  = 0;
	int                    num_checks = 0;
	int                    cyc        = 0;
	int                    i;
	int                    p;
	int                    offs[4]    = '{0, 1, 526, 527};

	////////////////////////////////////////////////////////////////////////
	// Core clock, 100 ns period
	always #50 core_clk = ~core_clk;

	sfr_read_path #(.PAGES(PG)) u_dut (
		.core_clk (core_clk),
		.rst      (rst),
		.cs_n     (cs_n),
		.sck      (sck),
		.si       (si),
		.so_o     (so_o),
		.so_oe    (so_oe),
		.ld_en    (ld_en),
		.ld_mode  (ld_mode),
		.ld_page  (ld_page),
		.ld_off   (ld_off),
		.ld_data  (ld_data)
	);

	sfr_host_model u_host (
		.core_clk (core_clk),
		.cs_n     (cs_n),
		.sck      (sck),
		.si       (si),
		.so_o     (so_o),
		.so_oe    (so_oe)
	);

	////////////////////////////////////////////////////////////////////////
	// Stored byte pattern, distinct per area, page and offset
	function automatic logic [7:0] pat(input int m, input int p, input int o);
		return 8'(o + 8'h35 * p + 8'h5B * m);
	endfunction : pat

	// Counted comparison
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk

	// One preload byte
	task automatic ld(input int m, input int p, input int o);
		ld_en   <= 1'b1;
		ld_mode <= sfr_mode_t'(m[1:0]);
		ld_page <= 13'(p);
		ld_off  <= 10'(o);
		ld_data <= pat(m, p, o);
		@(posedge core_clk);
	endtask : ld

	// Read frame and compare every byte against the stepped location
	task automatic rd(input string nm, input logic [7:0] opc, input int m,
		input int p, input int o, input int n, input bit m3);
		logic [23:0] adr;
		int          a;
		int          k;
		a   = (m < 2) ? 0 : m;
		adr = (m < 2) ? {1'b1, 13'(p), 10'(o)} : {14'h3FFF, 10'(o)};
		u_host.frame(opc, adr, (m < 2) ? 32 : 8, n, m3);
		chk({nm, " oe"}, 8'h00, {7'h00, u_host.oe_bad});
		chk({nm, " count"}, 8'(n), 8'(u_host.rx_q.size()));
		for (k = 0; k < n; k++) begin
			chk(nm, pat(a, p, o), u_host.rx_q[k]);
			if (o < 527) begin
				o++;
			end else begin
				o = 0;
				if (m == 0) p = (p + 1) % PG;
			end
		end
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	// Continuous read across last page into page zero, then page step
	task automatic test_cont;
		rd("cont end", SFR_OPC_CONT_RD, 0, PG - 1, 526, 4, 1'b0);
		rd("cont step", SFR_OPC_CONT_RD, 0, 1, 527, 2, 1'b1);
		$display("test_cont done");
	endtask : test_cont

	// Page read wraps inside its page
	task automatic test_page;
		rd("page", SFR_OPC_PAGE_RD, 1, 2, 526, 3, 1'b1);
		$display("test_page done");
	endtask : test_page

	// Both buffers wrap, untouched by the array reads before
	task automatic test_buf;
		rd("buf1", SFR_OPC_BUF1_RD, 2, 0, 527, 2, 1'b0);
		rd("buf2", SFR_OPC_BUF2_RD, 3, 0, 527, 2, 1'b1);
		u_host.frame(SFR_OPC_BUF1_RD, 24'hFF_FE58, 8, 2, 1'b0);
		chk("buf1 oor", SFR_OOR_BYTE, u_host.rx_q[0]);
		chk("buf1 oor wrap", pat(2, 0, 0), u_host.rx_q[1]);
		$display("test_buf done");
	endtask : test_buf

	// Unknown opcode never drives the output
	task automatic test_bad;
		u_host.frame(8'h00, 24'h00_0000, 32, 1, 1'b0);
		chk("bad oe", 8'h00, {7'h00, u_host.oe_seen});
		$display("test_bad done");
	endtask : test_bad

	// Counts, verdict and end of run
	task automatic complete_run;
		$display("Checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////
	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			complete_run();
		end
	end

	// Reset, preload, scenarios
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		for (i = 0; i < 4; i++) begin
			for (p = 0; p < PG; p++) ld(0, p, offs[i]);
			ld(2, 0, offs[i]);
			ld(3, 0, offs[i]);
		end
		ld_en <= 1'b0;
		repeat (4) @(posedge core_clk);
		test_cont();
		test_page();
		test_buf();
		test_bad();
		complete_run();
	end
endmodule : serial_flash_read_path_tb_top
`default_nettype wire
